// [prs_consts.svh]
// Timing counts, codes and reset values for the protection reaction sequencer
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_CLK_HZ 50000000
`define PRS_HALF_SINE_US 9823
// Longest gate-off time after a trigger: 1/512 of the half sine period, rounded down
`define PRS_GATE_OFF_CYC ((`PRS_HALF_SINE_US * (`PRS_CLK_HZ / 1000000)) / 512)
`define PRS_FAST_RESTART_MS 400
`define PRS_RESTART_MIN_MS 400
`define PRS_RESTART_MAX_MS 4000
`define PRS_CYC_PER_MS (`PRS_CLK_HZ / 1000)
`define PRS_FAST_RESTART_CYC (`PRS_FAST_RESTART_MS * `PRS_CYC_PER_MS)
`define PRS_DELAY_W 28
`define PRS_PULSE_W 16
`define PRS_CODE_NONE 16'h0000
`define PRS_CODE_IN_UV 16'h0040
`define PRS_CODE_OPEN_CS 16'h0001
`define PRS_CODE_ADC_WD 16'h0002
`define PRS_CODE_HW_WD 16'h0003
`define PRS_CODE_PARITY 16'h0004
`define PRS_CODE_CRC 16'h0005
`define PRS_CODE_TASK_WD 16'h0006
`define PRS_CODE_EMPTY_CFG 16'h0007
`define PRS_CODE_NO_ZCD 16'h0008
`define PRS_CODE_EXT 16'h0009
`endif

// [prs_pkg.sv]
// Types shared by the protection reaction sequencer
package prs_pkg;
  typedef enum logic [1:0] {PRS_REACT_FAST, PRS_REACT_AUTO, PRS_REACT_LATCH, PRS_REACT_STOP}
    prs_react_e;
  typedef enum logic [2:0] {PRS_ST_RUN, PRS_ST_GATE_OFF, PRS_ST_LATCH, PRS_ST_WAIT,
    PRS_ST_PULSE, PRS_ST_PRECHECK, PRS_ST_STOP} prs_state_e;
endpackage

// [prs_sense_detect.sv]
// Floating-pin detector and supply hysteresis keeper of the sequencer
`timescale 1ns/1ps
module prs_sense_detect
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_pin_level,
  input wire logic cs_switching,
  input wire logic hold_supply,
  input wire logic below_lower,
  input wire logic above_upper,
  output logic open_cs_evt,
  output logic hv_cell_on
);
  logic [3:0] float_cnt_r;
  logic [3:0] float_cnt_nxt;
  logic hv_r;
  logic hv_nxt;

  // Pulled-up pin stuck high while no switching means the pin floats
  always_comb
  begin
    float_cnt_nxt = float_cnt_r;
    if (cs_pin_level && !cs_switching)
    begin
      if (float_cnt_r != 4'hF)
        float_cnt_nxt = float_cnt_r + 4'h1;
    end
    else
      float_cnt_nxt = 4'h0;
    // Startup cell keeps supply inside the lockout window
    hv_nxt = hv_r;
    if (!hold_supply)
      hv_nxt = 1'b0;
    else if (below_lower)
      hv_nxt = 1'b1;
    else if (above_upper)
      hv_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      float_cnt_r <= 4'h0;
      hv_r <= 1'b0;
    end
    else
    begin
      float_cnt_r <= float_cnt_nxt;
      hv_r <= hv_nxt;
    end
  end

  assign open_cs_evt = (float_cnt_r == 4'hE); // One pulse, filtered
  assign hv_cell_on = hv_r;
endmodule

// [prs_sequencer.sv]
// Fault-reaction sequencer top: fault collection, reaction choice and restart timing
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_sequencer
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_pin_level,
  input wire logic cs_switching,
  input wire logic adc_sample_timeout,
  input wire logic hw_watchdog_expired,
  input wire logic mem_parity_error,
  input wire logic startup_check_done,
  input wire logic crc_mismatch,
  input wire logic task_watchdog_expired,
  input wire logic config_empty,
  input wire logic zero_crossing_sense_pin_seen,
  input wire logic input_uv_fault,
  input wire logic ext_fault,
  input wire logic [1:0] ext_fault_reaction,
  input wire logic fault_freeze_en,
  input wire logic [`PRS_DELAY_W-1:0] auto_restart_cycles,
  input wire logic [`PRS_PULSE_W-1:0] discharge_pulse_width,
  input wire logic supply_turn_off_threshold,
  input wire logic supply_lower_lockout_level,
  input wire logic supply_upper_lockout_level,
  input wire logic precheck_pass,
  input wire logic precheck_fail,
  input wire logic gate_request,
  output logic gate_enable,
  output logic gate_drive,
  output logic high_voltage_startup_pin,
  output logic power_saving_state_two,
  output logic stop_mode,
  output logic latched,
  output logic hw_restart,
  output logic [15:0] status_code
);
  localparam int FAST_CYC = `PRS_FAST_RESTART_CYC;
  localparam int MIN_CYC = `PRS_RESTART_MIN_MS * `PRS_CYC_PER_MS;
  localparam int MAX_CYC = `PRS_RESTART_MAX_MS * `PRS_CYC_PER_MS;
  localparam logic [`PRS_DELAY_W-1:0] FAST_DLY = FAST_CYC[`PRS_DELAY_W-1:0];
  localparam logic [`PRS_DELAY_W-1:0] MIN_DLY = MIN_CYC[`PRS_DELAY_W-1:0];
  localparam logic [`PRS_DELAY_W-1:0] MAX_DLY = MAX_CYC[`PRS_DELAY_W-1:0];

  prs_state_e state_r, state_nxt;
  prs_react_e react_r, react_nxt;
  logic [`PRS_DELAY_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] code_r, code_nxt;
  logic gate_en_r, gate_en_nxt;
  logic gate_drv_r, gate_drv_nxt;
  logic psm2_r, psm2_nxt;
  logic stop_r, stop_nxt;
  logic latch_r, latch_nxt;
  logic hwr_r, hwr_nxt;
  logic hv_req;
  logic open_cs_evt;
  logic any_fault;
  prs_react_e fault_react;
  logic [15:0] fault_code;

  // Pull-up float detector and supply keeper share one helper
  prs_sense_detect prs_sense_detect_i (
    .clk(clk),
    .rst(rst),
    .cs_pin_level(cs_pin_level),
    .cs_switching(cs_switching),
    .hold_supply(hv_req),
    .below_lower(supply_lower_lockout_level),
    .above_upper(supply_upper_lockout_level),
    .open_cs_evt(open_cs_evt),
    .hv_cell_on(high_voltage_startup_pin)
  );

  // Keeper runs in latch, wait and the gate-off step before them, never in stop where supply drains
  assign hv_req = (state_r == PRS_ST_LATCH) || (state_r == PRS_ST_WAIT) ||
                  (state_r == PRS_ST_GATE_OFF && react_r != PRS_REACT_STOP);

  // Fault collection with severity ranking; checked in ascending order so worse wins
  always_comb
  begin
    any_fault = 1'b0;
    fault_react = PRS_REACT_FAST;
    fault_code = `PRS_CODE_NONE;
    if (adc_sample_timeout)
    begin
      any_fault = 1'b1;
      fault_react = PRS_REACT_FAST;
      fault_code = `PRS_CODE_ADC_WD;
    end
    if (open_cs_evt || hw_watchdog_expired || mem_parity_error || task_watchdog_expired ||
        input_uv_fault)
    begin
      any_fault = 1'b1;
      fault_react = PRS_REACT_AUTO;
      if (input_uv_fault)
        fault_code = `PRS_CODE_IN_UV;
      else if (open_cs_evt)
        fault_code = `PRS_CODE_OPEN_CS;
      else if (hw_watchdog_expired)
        fault_code = `PRS_CODE_HW_WD;
      else if (mem_parity_error)
        fault_code = `PRS_CODE_PARITY;
      else
        fault_code = `PRS_CODE_TASK_WD;
    end
    if (ext_fault && (prs_react_e'(ext_fault_reaction) >= fault_react || !any_fault))
    begin
      any_fault = 1'b1;
      fault_react = prs_react_e'(ext_fault_reaction);
      fault_code = `PRS_CODE_EXT;
    end
    if (startup_check_done && (crc_mismatch || config_empty || !zero_crossing_sense_pin_seen))
    begin
      any_fault = 1'b1;
      fault_react = PRS_REACT_STOP;
      if (crc_mismatch)
        fault_code = `PRS_CODE_CRC;
      else if (config_empty)
        fault_code = `PRS_CODE_EMPTY_CFG;
      else
        fault_code = `PRS_CODE_NO_ZCD;
    end
    if (any_fault && fault_freeze_en)
      fault_react = PRS_REACT_STOP; // Lockout is a plain reset, outside this block
  end

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    react_nxt = react_r;
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    gate_en_nxt = gate_en_r;
    gate_drv_nxt = 1'b0;
    psm2_nxt = psm2_r;
    stop_nxt = stop_r;
    latch_nxt = latch_r;
    hwr_nxt = 1'b0;
    unique case (state_r)
      PRS_ST_RUN, PRS_ST_PRECHECK:
      begin
        gate_drv_nxt = gate_request && gate_en_r;
        if (any_fault)
        begin
          // Gate cut on the next edge, far inside the allowed window
          gate_en_nxt = 1'b0;
          gate_drv_nxt = 1'b0;
          react_nxt = fault_react;
          code_nxt = fault_code;
          cnt_nxt = '0;
          state_nxt = PRS_ST_GATE_OFF;
        end
        else if (state_r == PRS_ST_PRECHECK && precheck_fail)
        begin
          gate_en_nxt = 1'b0;
          gate_drv_nxt = 1'b0;
          react_nxt = PRS_REACT_AUTO;
          cnt_nxt = '0;
          state_nxt = PRS_ST_GATE_OFF;
        end
        else if (state_r == PRS_ST_PRECHECK && precheck_pass)
          state_nxt = PRS_ST_RUN;
      end
      PRS_ST_GATE_OFF:
      begin
        cnt_nxt = '0;
        unique case (react_r)
          PRS_REACT_STOP:
          begin
            stop_nxt = 1'b1;
            state_nxt = PRS_ST_STOP;
          end
          PRS_REACT_LATCH:
          begin
            latch_nxt = 1'b1;
            state_nxt = PRS_ST_LATCH;
          end
          PRS_REACT_AUTO:
          begin
            psm2_nxt = 1'b1;
            // Configured delay clamped into its legal span
            if (auto_restart_cycles < MIN_DLY)
              cnt_nxt = MIN_DLY;
            else if (auto_restart_cycles > MAX_DLY)
              cnt_nxt = MAX_DLY;
            else
              cnt_nxt = auto_restart_cycles;
            state_nxt = PRS_ST_WAIT;
          end
          PRS_REACT_FAST:
          begin
            psm2_nxt = 1'b1;
            cnt_nxt = FAST_DLY;
            state_nxt = PRS_ST_WAIT;
          end
        endcase
      end
      PRS_ST_LATCH:
      begin
        // Only the supply dropping out ends the latch
        if (supply_turn_off_threshold)
          hwr_nxt = 1'b1;
      end
      PRS_ST_STOP:
      begin
        // No keeper here, supply drains and the part restarts
        if (supply_turn_off_threshold)
          hwr_nxt = 1'b1;
      end
      PRS_ST_WAIT:
      begin
        if (cnt_r > {{(`PRS_DELAY_W-1){1'b0}}, 1'b1})
          cnt_nxt = cnt_r - 1'b1;
        else
        begin
          psm2_nxt = 1'b0;
          gate_drv_nxt = 1'b1;
          cnt_nxt = {{(`PRS_DELAY_W-`PRS_PULSE_W){1'b0}}, discharge_pulse_width};
          state_nxt = PRS_ST_PULSE;
        end
      end
      PRS_ST_PULSE:
      begin
        // Single pulse, width at least one cycle
        if (cnt_r > {{(`PRS_DELAY_W-1){1'b0}}, 1'b1})
        begin
          gate_drv_nxt = 1'b1;
          cnt_nxt = cnt_r - 1'b1;
        end
        else
        begin
          gate_en_nxt = 1'b1;
          state_nxt = PRS_ST_PRECHECK;
        end
      end
      default:
      begin
        // Corrupt state code: cut the gate and take the reaction path again
        gate_en_nxt = 1'b0;
        state_nxt = PRS_ST_GATE_OFF;
      end
    endcase
  end

  // State registers, synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= PRS_ST_RUN;
      react_r <= PRS_REACT_FAST;
      cnt_r <= '0;
      code_r <= `PRS_CODE_NONE;
      gate_en_r <= 1'b1;
      gate_drv_r <= 1'b0;
      psm2_r <= 1'b0;
      stop_r <= 1'b0;
      latch_r <= 1'b0;
      hwr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      react_r <= react_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      gate_en_r <= gate_en_nxt;
      gate_drv_r <= gate_drv_nxt;
      psm2_r <= psm2_nxt;
      stop_r <= stop_nxt;
      latch_r <= latch_nxt;
      hwr_r <= hwr_nxt;
    end
  end

  // Outputs straight from their flip-flops
  assign gate_enable = gate_en_r;
  assign gate_drive = gate_drv_r;
  assign power_saving_state_two = psm2_r;
  assign stop_mode = stop_r;
  assign latched = latch_r;
  assign hw_restart = hwr_r;
  assign status_code = code_r;
endmodule

// [prs_sequencer_sva.sv]
// Port-level assertions for the fault-reaction sequencer
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_sequencer_sva
(
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_sample_timeout,
  input wire logic hw_watchdog_expired,
  input wire logic mem_parity_error,
  input wire logic startup_check_done,
  input wire logic crc_mismatch,
  input wire logic input_uv_fault,
  input wire logic ext_fault,
  input wire logic fault_freeze_en,
  input wire logic gate_enable,
  input wire logic gate_drive,
  input wire logic high_voltage_startup_pin,
  input wire logic power_saving_state_two,
  input wire logic stop_mode,
  input wire logic latched,
  input wire logic hw_restart,
  input wire logic [15:0] status_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Gate enabled only while running or prechecking, where a fault is taken
  wire armed = gate_enable;
  wire plain = !fault_freeze_en && !startup_check_done && !ext_fault;
  a_gate_cut_fast: assert property (
    armed && adc_sample_timeout |=> !gate_enable && !gate_drive)
    else $error("gate not cut after sample timeout");
  a_crc_to_stop: assert property (
    armed && startup_check_done && crc_mismatch |=> ##1 stop_mode)
    else $error("integrity mismatch did not stop");
  a_stop_sticky: assert property (stop_mode |=> stop_mode && !gate_enable)
    else $error("stop mode left without reset");
  a_latch_holds: assert property (latched |=> latched && !power_saving_state_two)
    else $error("latch released early");
  a_uv_code: assert property (
    armed && input_uv_fault && plain |=> status_code == `PRS_CODE_IN_UV)
    else $error("undervoltage code wrong");
  a_freeze_stop: assert property (
    armed && fault_freeze_en && mem_parity_error |=> ##1 stop_mode)
    else $error("freeze did not force stop");
  a_wd_wait: assert property (
    armed && hw_watchdog_expired && plain |=> ##1 power_saving_state_two)
    else $error("watchdog did not start restart wait");
  a_restart_src: assert property (hw_restart |-> stop_mode || latched)
    else $error("hardware restart outside latch or stop");
  a_cell_off_stop: assert property (stop_mode && $past(stop_mode) |-> !high_voltage_startup_pin)
    else $error("startup cell on in stop mode");
  a_wait_no_gate: assert property (power_saving_state_two |-> !gate_enable)
    else $error("gate enabled while waiting");
endmodule

// [prs_supply_model.sv]
// Supply pin model: capacitor charged by the startup cell, drained by the core
`timescale 1ns/1ps
module prs_supply_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cell_on,
  output logic below_lower,
  output logic above_upper
);
  int v;
  // Charge faster than the core drains, so a stuck cell shows quickly
  always_ff @(posedge clk)
  begin
    if (rst)
      v <= 8;
    else
      v <= cell_on ? v + 2 : v - 1;
  end
  // Level comparators seen by the keeper
  assign below_lower = v < 10;
  assign above_upper = v > 40;
endmodule

// [tb_top.sv]
// Self-checking bench for the fault-reaction sequencer
`timescale 1ns/1ps
`include "prs_consts.svh"
module tb_top;
  logic clk, rst, frz, turn_off, below, above, ge, gd, hv, psm, stp, lat, hwr, greq;
  logic [1:0] ext_r;
  logic [9:0] fv;
  logic [15:0] code;
  int error_cnt, checks, i;
  // Case word: freeze, ext reaction, mode (0 wait, 1 latch, 2 stop), faults, code
  logic [30:0] tc [17] = '{
    {1'h0, 2'h0, 2'h0, 10'h001, 16'h0002},
    {1'h0, 2'h0, 2'h0, 10'h002, 16'h0003},
    {1'h0, 2'h0, 2'h0, 10'h004, 16'h0004},
    {1'h0, 2'h0, 2'h0, 10'h008, 16'h0006},
    {1'h0, 2'h0, 2'h0, 10'h010, 16'h0040},
    {1'h0, 2'h0, 2'h0, 10'h020, 16'h0009},
    {1'h0, 2'h1, 2'h0, 10'h020, 16'h0009},
    {1'h0, 2'h2, 2'h1, 10'h020, 16'h0009},
    {1'h0, 2'h3, 2'h2, 10'h020, 16'h0009},
    {1'h0, 2'h0, 2'h2, 10'h040, 16'h0005},
    {1'h0, 2'h0, 2'h2, 10'h080, 16'h0007},
    {1'h0, 2'h0, 2'h2, 10'h100, 16'h0008},
    {1'h0, 2'h0, 2'h0, 10'h200, 16'h0001},
    {1'h1, 2'h0, 2'h2, 10'h004, 16'h0004},
    {1'h0, 2'h0, 2'h2, 10'h044, 16'h0005},
    {1'h0, 2'h0, 2'h0, 10'h003, 16'h0003},
    {1'h0, 2'h2, 2'h1, 10'h022, 16'h0009}};
  prs_sequencer prs_sequencer_i (.clk(clk), .rst(rst), .cs_pin_level(fv[9]),
    .cs_switching(!fv[9]), .adc_sample_timeout(fv[0]), .hw_watchdog_expired(fv[1]),
    .mem_parity_error(fv[2]), .task_watchdog_expired(fv[3]), .input_uv_fault(fv[4]),
    .ext_fault(fv[5]), .crc_mismatch(fv[6]), .config_empty(fv[7]),
    .startup_check_done(|fv[8:6]), .zero_crossing_sense_pin_seen(!fv[8]),
    .ext_fault_reaction(ext_r), .fault_freeze_en(frz), .auto_restart_cycles(28'h1312D00),
    .discharge_pulse_width(16'h0004), .supply_turn_off_threshold(turn_off),
    .supply_lower_lockout_level(below), .supply_upper_lockout_level(above),
    .precheck_pass(1'b1), .precheck_fail(1'b0), .gate_request(greq), .gate_enable(ge),
    .gate_drive(gd), .high_voltage_startup_pin(hv), .power_saving_state_two(psm),
    .stop_mode(stp), .latched(lat), .hw_restart(hwr), .status_code(code));
  prs_supply_model prs_supply_model_i (.clk(clk), .rst(rst), .cell_on(hv),
    .below_lower(below), .above_upper(above));
  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // One fault case from reset; faults arriving later must be refused
  task run(input logic [30:0] c);
    int n, on, off;
    begin
      rst = 1'b1;
      frz = c[30];
      ext_r = c[29:28];
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk({ge, gd, psm, lat, stp, hwr, code[9:0]}, 16'hC000);
      fv = c[25:16];
      n = 0;
      on = 0;
      off = 0;
      // Bounded wait for the gate cut, capped at 1/512 of the half sine period
      while (ge !== 1'b0 && n < `PRS_GATE_OFF_CYC)
      begin
        @(negedge clk);
        n++;
      end
      if (ge !== 1'b0)
      begin
        error_cnt++;
        print_verdict;
      end
      else
      begin
        repeat (3) @(negedge clk);
        fv = 10'h044;
        repeat (2) @(negedge clk);
        fv = '0;
        chk(code, c[15:0]);
        chk({psm, lat, stp}, 3'h4 >> c[27:26]);
        chk({ge, gd}, 2'h0);
        repeat (300)
        begin
          @(negedge clk);
          on += (hv === 1'b1);
          off += (hv === 1'b0);
        end
        chk({on > 0, off > 0}, (c[27:26] == 2'h2) ? 2'h1 : 2'h3);
        turn_off = 1'b1;
        repeat (2) @(negedge clk);
        chk(hwr, c[27:26] != 2'h0);
        turn_off = 1'b0;
        $display("case done code=%h", c[15:0]);
      end
    end
  endtask
  // Main sequence: every fault source and reaction, and three mixes, each from a fresh reset
  initial
  begin
    rst = 1'b1;
    fv = '0;
    frz = 1'b0;
    ext_r = 2'h0;
    turn_off = 1'b0;
    greq = 1'b1;
    error_cnt = 0;
    checks = 0;
    for (i = 0; i < 17; i++)
      run(tc[i]);
    print_verdict;
  end
endmodule
bind prs_sequencer prs_sequencer_sva prs_sequencer_sva_i (.clk(clk), .rst(rst),
  .adc_sample_timeout(adc_sample_timeout), .hw_watchdog_expired(hw_watchdog_expired),
  .mem_parity_error(mem_parity_error), .startup_check_done(startup_check_done),
  .crc_mismatch(crc_mismatch), .input_uv_fault(input_uv_fault), .ext_fault(ext_fault),
  .fault_freeze_en(fault_freeze_en), .gate_enable(gate_enable), .gate_drive(gate_drive),
  .high_voltage_startup_pin(high_voltage_startup_pin), .stop_mode(stop_mode),
  .power_saving_state_two(power_saving_state_two), .latched(latched),
  .hw_restart(hw_restart), .status_code(status_code));
